// *** sadc_ctrl.sv ***
// Notes on behaviour
// - Skip leading zeros; first one starts.
// - Launch on falling, sample on rising clock.
// - Single/diff and polarity steer the multiplexer.
// - Single-ended versus ground, else channel difference.
// - Bit order one gives MSB first only.
// - After MSB-only data, zeros while selected.
// - Bit order zero: MSB first, then LSB.
// - One null bit before the result.
// - Unipolar conversion only.
// - Result code is straight binary.
// - Shared wire carries config in, result out.
// - Drive low on fourth fall after start.
// - Powered while select low, off when high.
// - Core powers down after conversion ends.
// - Clock and input ignored while deselected.
// - Sample opens before bit order, closes after.
// - Sample phase lasts one and half cycles.
// - Conversion takes twelve cycles, bit each.
// - Select high resets the serial sequencer.
`timescale 1ns/1ps
module sadc_ctrl
   import sadc_pkg::*;
(
   input  wire logic        clock,
   input  wire logic        reset,
   input  wire logic        select_shutdown_n,
   input  wire logic        shift_clock,
   input  wire logic        data_in,
   input  wire logic [11:0] comparator_code,
   output logic             data_out,
   output logic             data_out_en,
   output logic             core_power,
   output logic             serial_power,
   output logic             sample_window,
   output logic             mux_sel_channel_one,
   output logic             mux_differential,
   output logic             mux_neg_channel_one,
   output logic             conversion_done
);
   ////////////////////////////////////////////////////////////////////////////
   logic cs_n_s;
   logic sck_s;
   logic din_s;
   logic sck_d_ff;

   sadc_sync #(.RESET_VALUE(1'b1)) u_cs   (.clock(clock), .reset(reset), .async_in(select_shutdown_n), .sync_out(cs_n_s));
   sadc_sync #(.RESET_VALUE(1'b0)) u_sck  (.clock(clock), .reset(reset), .async_in(shift_clock), .sync_out(sck_s));
   sadc_sync #(.RESET_VALUE(1'b0)) u_din  (.clock(clock), .reset(reset), .async_in(data_in), .sync_out(din_s));

   // Data is sampled a few cycles after the pin edge; the bench clock keeps that well inside a half period.
   wire rise_w     = sck_s & ~sck_d_ff & ~cs_n_s;
   wire fall_w     = ~sck_s & sck_d_ff & ~cs_n_s;

   ////////////////////////////////////////////////////////////////////////////
   sadc_state_e state_ff,    nxt_state;
   logic [2:0]  cfg_ff,      nxt_cfg;
   logic [3:0]  cnt_ff,      nxt_cnt;
   logic [11:0] result_ff,   nxt_result;
   logic        dout_ff,     nxt_dout;
   logic        en_ff,       nxt_en;
   logic        core_ff,     nxt_core;
   logic        samp_ff,     nxt_samp;
   logic        done_ff,     nxt_done;
   logic [3:0]  conv_ff,     nxt_conv;

   wire order_msb_only = cfg_ff[CFG_ORDER_POS];
   wire cfg_last_w     = (cnt_ff == 4'(CONFIG_BITS - 1));
   wire res_last_w     = (cnt_ff == 4'(RESULT_BITS - 1));
   wire [11:0] code_w  = comparator_code;

   always_comb begin
      nxt_state  = state_ff;
      nxt_cfg    = cfg_ff;
      nxt_cnt    = cnt_ff;
      nxt_result = result_ff;
      nxt_dout   = dout_ff;
      nxt_en     = en_ff;
      nxt_core   = core_ff;
      nxt_samp   = samp_ff;
      nxt_done   = 1'b0;
      nxt_conv   = conv_ff;
      if (cs_n_s) begin
         nxt_state  = SADC_IDLE;
         nxt_cnt    = 4'h0;
         nxt_en     = 1'b0;
         nxt_dout   = 1'b0;
         nxt_core   = 1'b0;
         nxt_samp   = 1'b0;
         nxt_conv   = 4'h0;
      end else begin
         case (state_ff)
            SADC_IDLE: begin
               nxt_core = 1'b1;
               if (rise_w && din_s) begin
                  nxt_state = SADC_CFG;
                  nxt_cnt   = 4'h0;
               end
            end
            SADC_CFG: begin
               if (rise_w) begin
                  // Each bit lands in its own field, so the mux is already right when the window opens.
                  nxt_cfg[2'(CFG_SGL_POS) - cnt_ff[1:0]] = din_s;
                  nxt_cnt = cnt_ff + 4'h1;
                  if (cnt_ff == 4'(CFG_SGL_POS - 1)) begin
                     nxt_samp = 1'b1;
                  end
                  if (cfg_last_w) begin
                     nxt_state = SADC_NULL;
                     nxt_cnt   = 4'h0;
                  end
               end
            end
            SADC_NULL: begin
               // Falling edge after the last config bit is the fourth after start.
               if (fall_w) begin
                  nxt_samp  = 1'b0;
                  nxt_en    = 1'b1;
                  nxt_dout  = 1'b0;
                  nxt_state = SADC_MSB;
                  nxt_cnt   = 4'h0;
                  nxt_conv  = 4'h0;
               end
            end
            SADC_MSB: begin
               if (fall_w) begin
                  nxt_dout       = code_w[4'(RESULT_BITS - 1) - cnt_ff];
                  nxt_result     = code_w;
                  nxt_cnt        = cnt_ff + 4'h1;
                  nxt_conv       = cnt_ff + 4'h1;
                  if (res_last_w) begin
                     nxt_core  = 1'b0;
                     nxt_done  = 1'b1;
                     nxt_cnt   = 4'h1;
                     nxt_state = order_msb_only ? SADC_ZERO : SADC_LSB;
                  end
               end
            end
            SADC_LSB: begin
               if (fall_w) begin
                  nxt_dout = result_ff[cnt_ff];
                  nxt_cnt  = cnt_ff + 4'h1;
                  if (res_last_w) begin
                     nxt_state = SADC_ZERO;
                  end
               end
            end
            SADC_ZERO: begin
               if (fall_w) begin
                  nxt_dout = 1'b0;
               end
            end
            default: nxt_state = SADC_IDLE;
         endcase
      end
   end

   // The MSB-first LSB pass starts at bit 1: bit 0 was just sent and is shared.
   always_ff @(posedge clock) begin
      if (reset) begin
         state_ff  <= SADC_IDLE;
         sck_d_ff  <= 1'b0;
         cfg_ff    <= CFG_RESET;
         cnt_ff    <= 4'h0;
         result_ff <= RESULT_RESET;
         dout_ff   <= 1'b0;
         en_ff     <= 1'b0;
         core_ff   <= 1'b0;
         samp_ff   <= 1'b0;
         done_ff   <= 1'b0;
         conv_ff   <= 4'h0;
      end else begin
         state_ff  <= nxt_state;
         sck_d_ff  <= sck_s;
         cfg_ff    <= nxt_cfg;
         cnt_ff    <= nxt_cnt;
         result_ff <= nxt_result;
         dout_ff   <= nxt_dout;
         en_ff     <= nxt_en;
         core_ff   <= nxt_core;
         samp_ff   <= nxt_samp;
         done_ff   <= nxt_done;
         conv_ff   <= nxt_conv;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   assign data_out            = dout_ff;
   assign data_out_en         = en_ff;
   assign core_power          = core_ff;
   assign serial_power        = ~cs_n_s;
   assign sample_window       = samp_ff;
   assign conversion_done     = done_ff;
   assign mux_differential    = ~cfg_ff[CFG_SGL_POS];
   assign mux_sel_channel_one = cfg_ff[CFG_POL_POS];
   assign mux_neg_channel_one = ~cfg_ff[CFG_SGL_POS] & ~cfg_ff[CFG_POL_POS];

   ////////////////////////////////////////////////////////////////////////////
   property p_idle_quiet;
      @(posedge clock) disable iff (reset) cs_n_s |=> (!data_out_en && !core_power);
   endproperty
   idle_quiet_a: assert property (p_idle_quiet) else $error("outputs active while deselected");

   release_hold_a: assert property (@(posedge clock) disable iff (reset)
      (state_ff == SADC_CFG) |-> !data_out_en) else $error("driving during config");

   drive_low_a: assert property (@(posedge clock) disable iff (reset)
      $rose(data_out_en) |-> !data_out) else $error("first driven bit not low");

   zero_fill_a: assert property (@(posedge clock) disable iff (reset)
      (state_ff == SADC_ZERO) && $past(state_ff == SADC_ZERO) && $past(fall_w) |-> !data_out)
      else $error("non zero fill");

   core_off_a: assert property (@(posedge clock) disable iff (reset)
      done_ff |-> !core_power) else $error("core still powered");

   start_bit_a: assert property (@(posedge clock) disable iff (reset)
      (state_ff == SADC_IDLE) && rise_w && !din_s |=> (state_ff == SADC_IDLE)) else $error("zero taken as start");

   sample_close_a: assert property (@(posedge clock) disable iff (reset)
      $fell(sample_window) && !cs_n_s |-> data_out_en && (state_ff == SADC_MSB)) else $error("hold not at conversion start");

   conv_len_a: assert property (@(posedge clock) disable iff (reset)
      done_ff |-> (conv_ff == 4'(CONVERT_CYCLES))) else $error("conversion length wrong");

   mux_map_a: assert property (@(posedge clock) disable iff (reset)
      !mux_differential |-> !mux_neg_channel_one) else $error("ground reference lost");
endmodule

// *** sadc_host.sv ***
`timescale 1ns/1ps
module sadc_host (
   output logic      shift_clock,
   output logic      select_shutdown_n,
   output logic      data_in,
   input  wire logic data_out,
   input  wire logic data_out_en
);
   logic host_oe  = 1'b0;
   logic host_bit = 1'b0;
   // A released wire shows the inverse of the device bit, so a stale level never passes.
   assign data_in = data_out_en ? data_out : (host_oe ? host_bit : ~data_out);
   initial shift_clock = 1'b0;
   initial select_shutdown_n = 1'b1;
   //////////////////////////////////////////////////////////////////////////////
   // Low phase is longer than high so the synchronised output has settled by the rise.
   task automatic xfer(input int lead, input logic [2:0] cfg, input int nrd,
                       output logic [31:0] rd, output logic bad_en);
      logic [31:0] tx;
      int          nt;
      tx = {28'h0, 1'b1, cfg};
      nt = lead + 4;
      rd = '0;
      bad_en = 1'b0;
      select_shutdown_n = 1'b0;
      host_oe = 1'b1;
      #400;
      for (int i = 0; i < nt + nrd; i++) begin
         host_bit = (i < nt) ? tx[nt-1-i] : 1'b0;
         if (i == nt) host_oe = 1'b0;
         // A real host runs this clock far slower; the block only needs several system clocks per phase.
         #200 shift_clock = 1'b1;
         bad_en |= (data_out_en !== (i >= nt));
         if (i >= nt) rd = {rd[30:0], data_out};
         #120 shift_clock = 1'b0;
      end
      #200;
   endtask
   task automatic deselect(input int n);
      select_shutdown_n = 1'b1;
      host_oe = 1'b1;
      for (int i = 0; i < n; i++) begin
         host_bit = i[0];
         #200 shift_clock = 1'b1;
         #120 shift_clock = 1'b0;
      end
      host_oe = 1'b0;
      #200;
   endtask
endmodule

// *** sadc_pkg.sv ***
package sadc_pkg;
   localparam int unsigned RESULT_BITS       = 12;
   localparam int unsigned CONFIG_BITS       = 3;
   localparam int unsigned DRIVE_FALL_EDGE   = 4;
   localparam int unsigned CONVERT_CYCLES    = 12;
   localparam int unsigned CFG_SGL_POS       = 2;
   localparam int unsigned CFG_POL_POS       = 1;
   localparam int unsigned CFG_ORDER_POS     = 0;
   localparam logic [2:0]  CFG_RESET         = 3'h0;
   localparam logic [11:0] RESULT_RESET      = 12'h000;
   localparam logic [1:0]  SYNC_RESET        = 2'h3;

   typedef enum logic [2:0] {
      SADC_IDLE  = 3'b000,
      SADC_CFG   = 3'b001,
      SADC_NULL  = 3'b010,
      SADC_MSB   = 3'b011,
      SADC_LSB   = 3'b100,
      SADC_ZERO  = 3'b101
   } sadc_state_e;
endpackage

// *** sadc_sync.sv ***
`timescale 1ns/1ps
module sadc_sync
   import sadc_pkg::*;
#(
   parameter logic RESET_VALUE = 1'b1
) (
   input  wire logic clock,
   input  wire logic reset,
   input  wire logic async_in,
   output logic      sync_out
);
   logic first_ff;

   // The first stage feeds only the second one, so metastability cannot spread.
   always_ff @(posedge clock) begin
      if (reset) begin
         first_ff <= RESET_VALUE;
         sync_out <= RESET_VALUE;
      end else begin
         first_ff <= async_in;
         sync_out <= first_ff;
      end
   end
endmodule

// *** test_serial_adc_mux_control.sv ***
`timescale 1ns/1ps
module test_serial_adc_mux_control;
   import sadc_pkg::*;
   logic        clock = 1'b0;
   logic        reset = 1'b1;
   logic [11:0] comparator_code = 12'h000;
   wire logic   shift_clock, select_shutdown_n, data_in, data_out, data_out_en, core_power;
   wire logic   serial_power, sample_window, mux_sel_channel_one, mux_differential;
   wire logic   mux_neg_channel_one, conversion_done;
   int          err_count = 0;
   int          compares = 0;
   int          cycles = 0;
   int          done_cnt = 0;
   int          win_cnt = 0;
   int          conv_clk = 0;
   int          conv_len = 0;
   int          core_cnt = 0;
   logic        win_prev = 1'b0;
   logic [2:0]  win_mux = 3'h0;
   // A 320 ns shift period spans eight 40 ns system clocks.
   localparam int SHIFT_CLOCKS = 8;
   sadc_ctrl u_sadc_ctrl (.clock(clock), .reset(reset), .select_shutdown_n(select_shutdown_n),
      .shift_clock(shift_clock), .data_in(data_in), .comparator_code(comparator_code),
      .data_out(data_out), .data_out_en(data_out_en), .core_power(core_power),
      .serial_power(serial_power), .sample_window(sample_window),
      .mux_sel_channel_one(mux_sel_channel_one), .mux_differential(mux_differential),
      .mux_neg_channel_one(mux_neg_channel_one), .conversion_done(conversion_done));
   sadc_host u_sadc_host (.shift_clock(shift_clock), .select_shutdown_n(select_shutdown_n),
      .data_in(data_in), .data_out(data_out), .data_out_en(data_out_en));
   initial forever #20 clock = ~clock;
   // The ceiling allows about two and a half times the cycles that the scenarios need.
   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (conversion_done === 1'b1) done_cnt <= done_cnt + 1;
      if (sample_window === 1'b1) win_cnt <= win_cnt + 1;
      conv_clk <= (sample_window === 1'b1) ? 0 : conv_clk + 1;
      if (conversion_done === 1'b1) conv_len <= conv_clk;
      if (core_power === 1'b1) core_cnt <= core_cnt + 1;
      win_prev <= sample_window;
      if (sample_window === 1'b1 && win_prev !== 1'b1) win_mux <= {mux_differential, mux_sel_channel_one,
                                                                   mux_neg_channel_one};
      if (cycles == 8000) begin
         err_count++;
         report_and_stop();
      end
   end
   //////////////////////////////////////////////////////////////////////////////
   task automatic report_and_stop();
      if (err_count == 0 && compares > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   function automatic logic [31:0] expect_bits(input logic [11:0] c, input logic msb_only);
      logic [31:0] e;
      e = {6'h0, 1'b0, c, 13'h0};
      for (int i = 1; i < 12; i++) if (!msb_only) e[13-i] = c[i];
      return e;
   endfunction
   task automatic run_check(input int lead, input logic [2:0] cfg, input logic [11:0] code);
      logic [31:0] rd;
      logic        bad;
      int          d0;
      int          w0;
      int          c0;
      comparator_code = code;
      d0 = done_cnt;
      w0 = win_cnt;
      c0 = core_cnt;
      u_sadc_host.xfer(lead, cfg, 26, rd, bad);
      cmp_val(rd, expect_bits(code, cfg[0]));
      cmp_val(32'(bad), 32'h0);
      cmp_val({29'h0, mux_differential, mux_sel_channel_one, mux_neg_channel_one},
              {29'h0, ~cfg[2], cfg[1], ~cfg[2] & ~cfg[1]});
      cmp_val(32'(done_cnt - d0), 32'h1);
      cmp_val(32'(conv_len), 32'(CONVERT_CYCLES * SHIFT_CLOCKS));
      cmp_val({29'h0, win_mux}, {29'h0, ~cfg[2], cfg[1], ~cfg[2] & ~cfg[1]});
      cmp_val(32'(core_cnt > c0), 32'h1);
      cmp_val({30'h0, core_power, serial_power}, 32'h1);
      cmp_val(32'((win_cnt - w0) inside {[10:13]}), 32'h1);
      u_sadc_host.deselect(2);
      cmp_val({29'h0, serial_power, data_out_en, core_power}, 32'h0);
   endtask
   //////////////////////////////////////////////////////////////////////////////
   task automatic t_modes();
      for (int c = 0; c < 8; c++) run_check(0, 3'(c), 12'ha5c ^ {4{3'(c)}});
   endtask
   task automatic t_lead();
      run_check(3, 3'b110, 12'hfff);
      run_check(1, 3'b001, 12'h001);
   endtask
   // Aborting mid-result must leave no trace on the next exchange.
   task automatic t_abort();
      logic [31:0] rd;
      logic        bad;
      int          d0;
      d0 = done_cnt;
      comparator_code = 12'h7e1;
      u_sadc_host.xfer(0, 3'b011, 5, rd, bad);
      cmp_val(rd, 32'h7);
      cmp_val(32'(bad), 32'h0);
      u_sadc_host.deselect(6);
      cmp_val(32'(done_cnt - d0), 32'h0);
      cmp_val({29'h0, core_power, data_out_en, sample_window}, 32'h0);
      run_check(0, 3'b100, 12'h3c9);
   endtask
   initial begin
      repeat (5) @(posedge clock);
      @(negedge clock);
      reset = 1'b0;
      repeat (4) @(negedge clock);
      t_modes();
      t_lead();
      t_abort();
      report_and_stop();
   end
endmodule
